// File: shared/pdx_regs.vh
// constants for the programmable i/o crosspoint: geometry, register map, field layouts
// assumes inclusion by both design files; definitions only
`ifndef PDX_REGS_VH
`define PDX_REGS_VH

`define PDX_NUM_IO 80
`define PDX_SET_SIZE 20
`define PDX_SET_A_BASE 0
`define PDX_SET_B_BASE 20
`define PDX_SET_C_BASE 40
`define PDX_SET_D_BASE 60
`define PDX_OE_BASE 0
`define PDX_CLK_BASE 20
`define PDX_SEL1_BASE 40
`define PDX_SEL2_BASE 60
`define PDX_CFG_WORDS 3
`define PDX_CFG_DEPTH 240
`define PDX_CFG_LIMIT 12'h500
`define PDX_STAT_PIN_LO 12'h800
`define PDX_STAT_PIN_MID 12'h804
`define PDX_STAT_PIN_HI 12'h808
`define PDX_STAT_CTRL 12'h80c
`define PDX_CFG_RESET 32'h00000000

// word 0: data path
`define PDX_W0_CASC 23:20
`define PDX_W0_MODE 25:24
`define PDX_W0_PATH_B 26
`define PDX_W0_OUT_INV 27
`define PDX_W0_FIX_EN 28
`define PDX_W0_FIX_VAL 29
`define PDX_W0_PULL_UP 30
`define PDX_W0_KEEPER 31
// word 1: controls
`define PDX_W1_OE_IDX 4:0
`define PDX_W1_OE_MODE 6:5
`define PDX_W1_OE_POL 7
`define PDX_W1_CLK_IDX 12:8
`define PDX_W1_CLK_GLB 13
`define PDX_W1_CLK_GSEL 14
`define PDX_W1_CLK_POL 15
`define PDX_W1_CE_IDX 20:16
`define PDX_W1_CE_USE 21
`define PDX_W1_CE_GLB 22
`define PDX_W1_CE_GSEL 23
`define PDX_W1_CE_POL 24
`define PDX_W1_SLO_SET2 25
`define PDX_W1_SLO_POL 26
`define PDX_W1_SHI_SET2 27
`define PDX_W1_SHI_POL 28
`define PDX_W1_OPEN_DRAIN 29
// word 2: select pin indices
`define PDX_W2_SLO_IDX 4:0
`define PDX_W2_SHI_IDX 9:5

`define PDX_MODE_COMB 2'h0
`define PDX_MODE_LATCH 2'h1
`define PDX_MODE_REG 2'h2
`define PDX_OE_OFF 2'h0
`define PDX_OE_ON 2'h1
`define PDX_OE_PIN 2'h2

`endif

// File: logic/pdx_cell.v
// one i/o cell: dynamic 4:1 mux with cascade, latch or register, polarity and drive control
// assumes control pins already picked from their pin sets by the crosspoint top
`timescale 1ns/10ps
`include "pdx_regs.vh"
module pdx_cell (
	input wire core_clk_i,
	input wire rst_i,
	input wire [31:0] word0_i,
	input wire [31:0] word1_i,
	input wire [3:0] direct_i,
	input wire [3:0] casc_i,
	input wire oe_pin_i,
	input wire clk_pin_i,
	input wire ce_pin_i,
	input wire sel_low_raw_i,
	input wire sel_high_raw_i,
	input wire [1:0] global_clock_i,
	input wire pin_in_i,
	input wire drive_ok_i,
	output wire direct_mux_o,
	output wire pool_o,
	output wire pin_out_o,
	output wire pin_oe_o,
	output wire pull_up_o,
	output wire keeper_o
);
	function gray_mux;
		input [3:0] d;
		input hi;
		input lo;
		begin
			case ({hi, lo})
				2'h0: gray_mux = d[0];
				2'h1: gray_mux = d[1];
				2'h3: gray_mux = d[2];
				default: gray_mux = d[3];
			endcase
		end
	endfunction

	wire [1:0] mode = word0_i[`PDX_W0_MODE];
	wire path_b = word0_i[`PDX_W0_PATH_B];
	wire stored_path = (mode != `PDX_MODE_COMB);
	// polarity bit set means active low
	wire sel_low = sel_low_raw_i ^ word1_i[`PDX_W1_SLO_POL];
	wire sel_high = sel_high_raw_i ^ word1_i[`PDX_W1_SHI_POL];
	wire [3:0] eff_in = (word0_i[`PDX_W0_CASC] & casc_i) |
		(~word0_i[`PDX_W0_CASC] & direct_i);
	// cascade taps see only the neighbour's direct mux, so no loop can form
	assign direct_mux_o = gray_mux(direct_i, sel_high, sel_low);
	wire mux_out = gray_mux(eff_in, sel_high, sel_low);
	wire clk_src = word1_i[`PDX_W1_CLK_GLB] ?
		global_clock_i[word1_i[`PDX_W1_CLK_GSEL]] : clk_pin_i;
	wire adj_clk = clk_src ^ word1_i[`PDX_W1_CLK_POL];
	wire ce_src = word1_i[`PDX_W1_CE_GLB] ?
		global_clock_i[word1_i[`PDX_W1_CE_GSEL]] : ce_pin_i;
	wire ce = ~word1_i[`PDX_W1_CE_USE] | (ce_src ^ word1_i[`PDX_W1_CE_POL]);
	wire d_in = path_b ? pin_in_i : mux_out;
	reg clk_prev;
	reg stored;

	// pin clocks are sampled, so a cell edge is seen one core cycle late
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			// start high: a clock already high at release is not an edge
			clk_prev <= 1'b1;
			stored <= 1'b0;
		end else begin
			clk_prev <= adj_clk;
			if (ce) begin
				case (mode)
					`PDX_MODE_LATCH: begin
						if (adj_clk)
							stored <= d_in;
					end
					`PDX_MODE_REG: begin
						if (adj_clk && !clk_prev)
							stored <= d_in;
					end
					default: stored <= stored;
				endcase
			end
		end
	end

	assign pool_o = (path_b && stored_path) ? stored : pin_in_i;
	wire core_val = (!path_b && stored_path) ? stored : mux_out;
	wire out_val = word0_i[`PDX_W0_FIX_EN] ? word0_i[`PDX_W0_FIX_VAL] :
		(core_val ^ word0_i[`PDX_W0_OUT_INV]);
	wire [1:0] oe_mode = word1_i[`PDX_W1_OE_MODE];
	wire oe_want = word0_i[`PDX_W0_FIX_EN] | (oe_mode == `PDX_OE_ON) |
		((oe_mode == `PDX_OE_PIN) & (oe_pin_i ^ word1_i[`PDX_W1_OE_POL]));
	wire open_drain = word1_i[`PDX_W1_OPEN_DRAIN];
	assign pin_oe_o = drive_ok_i & oe_want & (~open_drain | ~out_val);
	assign pin_out_o = open_drain ? 1'b0 : out_val;
	assign pull_up_o = word0_i[`PDX_W0_PULL_UP];
	assign keeper_o = word0_i[`PDX_W0_KEEPER];
endmodule

// File: logic/pdx_crosspoint.v
// crosspoint top: configuration store with avalon-mm slave, pin sets and 80 i/o cells
// assumes pins synchronous to core_clk_i; a board pad resolves out, oe, pull-up and keeper
`timescale 1ns/10ps
`include "pdx_regs.vh"
module pdx_crosspoint (
	input wire core_clk_i,
	input wire rst_i,
	input wire [11:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire [79:0] pin_in_i,
	output wire [79:0] pin_out_o,
	output wire [79:0] pin_oe_o,
	output wire [79:0] pin_pull_up_o,
	output wire [79:0] pin_keeper_o,
	input wire [1:0] global_clock_i,
	input wire power_good_i,
	input wire program_enable_pin_i,
	input wire test_output_enable_pin_i
);
	function pick;
		input [19:0] set;
		input [4:0] idx;
		begin
			pick = (idx < 5'd20) ? set[idx] : 1'b0;
		end
	endfunction

	// configuration store: not touched by rst_i, it stands for non-volatile cells
	reg [31:0] cfg_mem [0:`PDX_CFG_DEPTH-1];
	integer k;
	initial begin
		for (k = 0; k < `PDX_CFG_DEPTH; k = k + 1)
			cfg_mem[k] = `PDX_CFG_RESET;
	end

	wire [79:0] pool;
	wire [79:0] direct_mux;
	reg ack;
	reg run_q;
	wire req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack;

	wire in_cfg = (avs_address < `PDX_CFG_LIMIT) && (avs_address[3:2] != 2'h3);
	wire [7:0] cfg_index = ({1'b0, avs_address[10:4]} * 8'd3) + {6'h00, avs_address[3:2]};
	reg [31:0] next_readdata;
	reg [31:0] merged;
	integer b;

	always @* begin
		next_readdata = 32'h00000000;
		if (in_cfg)
			next_readdata = cfg_mem[cfg_index];
		else begin
			case (avs_address)
				`PDX_STAT_PIN_LO: next_readdata = pin_in_i[31:0];
				`PDX_STAT_PIN_MID: next_readdata = pin_in_i[63:32];
				`PDX_STAT_PIN_HI: next_readdata = {16'h0000, pin_in_i[79:64]};
				`PDX_STAT_CTRL: next_readdata = {29'h00000000, test_output_enable_pin_i,
					power_good_i, program_enable_pin_i};
				default: next_readdata = 32'h00000000;
			endcase
		end
	end

	always @* begin
		merged = cfg_mem[cfg_index];
		for (b = 0; b < 4; b = b + 1) begin
			if (avs_byteenable[b])
				merged[b*8 +: 8] = avs_writedata[b*8 +: 8];
		end
	end

	// one wait cycle per access; read data captured at the first edge
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else if (req && !ack) begin
			ack <= 1'b1;
			// writes leave the last read data standing
			if (avs_read)
				avs_readdata <= next_readdata;
		end else begin
			ack <= 1'b0;
		end
	end

	// writes land only while programming is enabled; others are dropped silently
	always @(posedge core_clk_i) begin
		if (avs_write && ack && in_cfg && program_enable_pin_i)
			cfg_mem[cfg_index] <= merged;
	end

	// drivers stay off through reset and until supply reports good
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			run_q <= 1'b0;
		else
			run_q <= 1'b1;
	end
	wire drive_ok = run_q & power_good_i & test_output_enable_pin_i;

	genvar i;
	generate
		for (i = 0; i < `PDX_NUM_IO; i = i + 1) begin : g_cell
			wire [31:0] w0 = cfg_mem[i*`PDX_CFG_WORDS];
			wire [31:0] w1 = cfg_mem[i*`PDX_CFG_WORDS+1];
			wire [31:0] w2 = cfg_mem[i*`PDX_CFG_WORDS+2];
			wire [3:0] direct;
			wire [3:0] casc;
			// data input j reaches only pin set j of the routing pool
			assign direct[0] = pick(pool[`PDX_SET_A_BASE +: 20], w0[4:0]);
			assign direct[1] = pick(pool[`PDX_SET_B_BASE +: 20], w0[9:5]);
			assign direct[2] = pick(pool[`PDX_SET_C_BASE +: 20], w0[14:10]);
			assign direct[3] = pick(pool[`PDX_SET_D_BASE +: 20], w0[19:15]);
			// neighbours wrap around the ring
			assign casc[0] = direct_mux[(i + 78) % 80];
			assign casc[1] = direct_mux[(i + 79) % 80];
			assign casc[2] = direct_mux[(i + 1) % 80];
			assign casc[3] = direct_mux[(i + 2) % 80];
			wire oe_pin = pick(pool[`PDX_OE_BASE +: 20], w1[`PDX_W1_OE_IDX]);
			wire clk_pin = pick(pool[`PDX_CLK_BASE +: 20], w1[`PDX_W1_CLK_IDX]);
			wire ce_pin = pick(pool[`PDX_CLK_BASE +: 20], w1[`PDX_W1_CE_IDX]);
			wire slo_s1 = pick(pool[`PDX_SEL1_BASE +: 20], w2[`PDX_W2_SLO_IDX]);
			wire slo_s2 = pick(pool[`PDX_SEL2_BASE +: 20], w2[`PDX_W2_SLO_IDX]);
			wire shi_s1 = pick(pool[`PDX_SEL1_BASE +: 20], w2[`PDX_W2_SHI_IDX]);
			wire shi_s2 = pick(pool[`PDX_SEL2_BASE +: 20], w2[`PDX_W2_SHI_IDX]);
			wire slo = w1[`PDX_W1_SLO_SET2] ? slo_s2 : slo_s1;
			wire shi = w1[`PDX_W1_SHI_SET2] ? shi_s2 : shi_s1;
			pdx_cell u_cell (
				.core_clk_i(core_clk_i),
				.rst_i(rst_i),
				.word0_i(w0),
				.word1_i(w1),
				.direct_i(direct),
				.casc_i(casc),
				.oe_pin_i(oe_pin),
				.clk_pin_i(clk_pin),
				.ce_pin_i(ce_pin),
				.sel_low_raw_i(slo),
				.sel_high_raw_i(shi),
				.global_clock_i(global_clock_i),
				.pin_in_i(pin_in_i[i]),
				.drive_ok_i(drive_ok),
				.direct_mux_o(direct_mux[i]),
				.pool_o(pool[i]),
				.pin_out_o(pin_out_o[i]),
				.pin_oe_o(pin_oe_o[i]),
				.pull_up_o(pin_pull_up_o[i]),
				.keeper_o(pin_keeper_o[i])
			);
		end
	endgenerate
endmodule

// File: dv/pdx_crosspoint_assertions.sv
// port checker for the crosspoint: bus wait state, status reads, drive gating
// assumes bind to pdx_crosspoint, one clock domain
`timescale 1ns/10ps
module pdx_crosspoint_assertions (
	input wire core_clk_i,
	input wire rst_i,
	input wire [11:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire [79:0] pin_in_i,
	input wire [79:0] pin_oe_o,
	input wire power_good_i,
	input wire program_enable_pin_i,
	input wire test_output_enable_pin_i
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_start;
		$rose(avs_read | avs_write);
	endsequence
	sequence s_rd_done;
		avs_read && !avs_waitrequest;
	endsequence
	AST_OE_PWR: assert property (!power_good_i |-> pin_oe_o == 80'h0)
		else $error("drive while power low");
	AST_OE_TOE: assert property (!test_output_enable_pin_i |-> pin_oe_o == 80'h0)
		else $error("drive while outputs disabled");
	AST_ONE_WAIT: assert property (s_start |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("wait state count wrong");
	AST_IDLE: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
		else $error("wait without request");
	AST_UNMAPPED: assert property (s_rd_done ##0 avs_address[11:8] == 4'h6 |->
		avs_readdata == 32'h0) else $error("unmapped read not zero");
	AST_CTRL_RD: assert property (s_rd_done ##0 avs_address == 12'h80c |->
		avs_readdata[2:0] == {test_output_enable_pin_i, power_good_i, program_enable_pin_i})
		else $error("control status wrong");
	// guard: pads must be quiet long enough to pass any input sampling
	AST_PIN_RD: assert property (s_rd_done ##0 avs_address == 12'h800 ##0
		pin_in_i[31:0] == $past(pin_in_i[31:0], 3) |-> avs_readdata == pin_in_i[31:0])
		else $error("pin status wrong");
	AST_RD_HOLD: assert property (!avs_read ##1 !avs_read |-> $stable(avs_readdata))
		else $error("read data moved");
endmodule
bind pdx_crosspoint pdx_crosspoint_assertions chk (.core_clk_i, .rst_i, .avs_address,
	.avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .pin_in_i, .pin_oe_o,
	.power_good_i, .program_enable_pin_i, .test_output_enable_pin_i);

// File: dv/pdx_board.sv
// board devices on the pads: drivers, pull-ups, floating lines
// assumes the bench sets drive values; the design's drive wins
`timescale 1ns/10ps
module pdx_board (
	input wire [79:0] pin_out_i,
	input wire [79:0] pin_oe_i,
	input wire [79:0] pin_pull_up_i,
	input wire [79:0] drv_en_i,
	input wire [79:0] drv_val_i,
	output wire [79:0] pin_in_o
);
	// undriven pad: pull-up level, else inverse of last, never a lucky guess
	wire [79:0] idle = pin_pull_up_i | ~pin_out_i;
	assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & (drv_en_i & drv_val_i | ~drv_en_i & idle));
endmodule

// File: dv/pdx_crosspoint_tb.sv
// bench for the crosspoint: bus, routing, fixed levels, register, drive gating
// assumes the board model resolves pads; inputs move right after rising edges
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module pdx_crosspoint_tb;
	logic core_clk_i = 0, rst_i = 1, avs_read = 0, avs_write = 0;
	logic power_good_i = 1, program_enable_pin_i = 1, test_output_enable_pin_i = 1;
	logic [11:0] avs_address = 0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 0, q;
	logic [1:0] global_clock_i = 0;
	logic [79:0] drv_val = 0;
	wire [31:0] avs_readdata;
	wire avs_waitrequest;
	wire [79:0] pin_in_i, pin_out_o, pin_oe_o, pin_pull_up_o, pin_keeper_o;
	int mismatches = 0, n_tests = 0;
	always #5 core_clk_i = ~core_clk_i;
	pdx_crosspoint uut (.core_clk_i, .rst_i, .avs_address, .avs_read, .avs_write,
		.avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .pin_in_i,
		.pin_out_o, .pin_oe_o, .pin_pull_up_o, .pin_keeper_o, .global_clock_i,
		.power_good_i, .program_enable_pin_i, .test_output_enable_pin_i);
	pdx_board board (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .pin_pull_up_i(pin_pull_up_o),
		.drv_en_i({1'b0, {79{1'b1}}}), .drv_val_i(drv_val), .pin_in_o(pin_in_i));
	task automatic step;
		@(posedge core_clk_i);
		@(negedge core_clk_i);
	endtask
	// host side of the programming port
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		logic w;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		// only the watchdog ends a wait that never completes
		do begin
			@(posedge core_clk_i);
			w = avs_waitrequest;
			q = avs_readdata;
		end while (w !== 1'b0);
		avs_read <= 0;
		avs_write <= 0;
		@(posedge core_clk_i);
	endtask
	task automatic cfg(input int c, input logic [31:0] w0, w1, w2);
		bus(1, 12'(c * 16), w0);
		bus(1, 12'(c * 16 + 4), w1);
		bus(1, 12'(c * 16 + 8), w2);
	endtask
	task automatic t_mux;
		logic [3:0] pat;
		logic [1:0] s, src;
		cfg(5, 32'h20c41, 32'h20, 32'h16a);
		cfg(6, 32'h20c41, 32'h20, 32'h16a);
		for (int i = 0; i < 8; i++) begin
			pat = i[2] ? 4'ha : 4'h5;
			s = i[1:0];
			src = {s[1], s[1] ^ s[0]};
			{drv_val[64], drv_val[43], drv_val[22], drv_val[1]} <= pat;
			{drv_val[51], drv_val[50]} <= s;
			step;
			`CHK("mux", pat[src], pin_out_o[5])
			`CHK("fanout", pat[src], pin_out_o[6])
			@(posedge core_clk_i);
		end
		cfg(6, 32'h20c41, 32'h04000020, 32'h16a);
		step;
		`CHK("sel_pol", 1'b1, pin_out_o[6])
		`CHK("oe_on", 1'b1, pin_oe_o[5])
		@(posedge core_clk_i);
	endtask
	task automatic t_fixed;
		for (int v = 0; v < 2; v++) begin
			cfg(7, 32'h10000000 | (v << 29), 32'h0, 32'h0);
			step;
			`CHK("fix_out", v[0], pin_out_o[7])
			`CHK("fix_oe", 1'b1, pin_oe_o[7])
			@(posedge core_clk_i);
		end
	endtask
	task automatic t_reg;
		logic [8:0] tab = 9'b111_001_010;
		cfg(8, 32'h02000001, 32'h00e02020, 32'h0);
		for (int i = 0; i < 3; i++) begin
			drv_val[1] <= tab[8 - 3 * i];
			global_clock_i <= {tab[7 - 3 * i], 1'b0};
			repeat (3) @(posedge core_clk_i);
			global_clock_i[0] <= 1'b1;
			repeat (2) step;
			`CHK("reg_out", tab[6 - 3 * i], pin_out_o[8])
			@(posedge core_clk_i);
		end
	endtask
	// cell 10: inverted out, oe from pin 2 active low, pad options, open drain
	// cell 11 cascades cell 10's mux; cell 12 latches pin 12 into the pool for cell 13
	task automatic t_pad;
		cfg(10, 32'hc8000001, 32'hc2, 32'h0);
		cfg(11, 32'h00200000, 32'h20, 32'h1);
		cfg(12, 32'h05000000, 32'h300, 32'h0);
		cfg(13, 32'hc, 32'h20, 32'h0);
		drv_val[1] <= 0;
		drv_val[2] <= 0;
		drv_val[41] <= 1;
		drv_val[20] <= 1;
		step;
		`CHK("inv_out", 1'b1, pin_out_o[10])
		`CHK("oe_pin_pol", 1'b1, pin_oe_o[10])
		`CHK("pull_up", 1'b1, pin_pull_up_o[10])
		`CHK("keeper", 1'b1, pin_keeper_o[10])
		`CHK("casc_lo", 1'b0, pin_out_o[11])
		@(posedge core_clk_i);
		drv_val[1] <= 1;
		drv_val[2] <= 1;
		drv_val[20] <= 0;
		step;
		`CHK("oe_pin_off", 1'b0, pin_oe_o[10])
		`CHK("casc_hi", 1'b1, pin_out_o[11])
		@(posedge core_clk_i);
		cfg(10, 32'hc8000001, 32'h200000c2, 32'h0);
		drv_val[2] <= 0;
		step;
		`CHK("od_oe_low", 1'b1, pin_oe_o[10])
		`CHK("od_out", 1'b0, pin_out_o[10])
		@(posedge core_clk_i);
		drv_val[1] <= 0;
		step;
		`CHK("od_oe_high", 1'b0, pin_oe_o[10])
		@(posedge core_clk_i);
		drv_val[23] <= 1;
		drv_val[12] <= 1;
		step;
		`CHK("latch_open", 1'b1, pin_out_o[13])
		@(posedge core_clk_i);
		drv_val[23] <= 0;
		drv_val[12] <= 0;
		step;
		`CHK("latch_hold", 1'b1, pin_out_o[13])
		@(posedge core_clk_i);
		drv_val[23] <= 1;
		step;
		`CHK("latch_follow", 1'b0, pin_out_o[13])
		@(posedge core_clk_i);
	endtask
	task automatic t_prot;
		program_enable_pin_i <= 0;
		bus(1, 12'h050, 32'hffffffff);
		program_enable_pin_i <= 1;
		bus(0, 12'h050, 0);
		`CHK("locked", 32'h20c41, q)
		avs_byteenable <= 4'h1;
		bus(1, 12'h098, 32'hffffffff);
		avs_byteenable <= 4'hf;
		bus(0, 12'h098, 0);
		`CHK("lane", 32'hff, q)
		bus(0, 12'h600, 0);
		`CHK("unmapped", 32'h0, q)
		bus(0, 12'h80c, 0);
		`CHK("ctrl", 3'b111, q[2:0])
		bus(0, 12'h800, 0);
		`CHK("pins", pin_in_i[31:0], q)
		rst_i <= 1;
		step;
		`CHK("rst_oe", 80'h0, pin_oe_o)
		@(posedge core_clk_i);
		rst_i <= 0;
		@(posedge core_clk_i);
		bus(0, 12'h050, 0);
		`CHK("kept", 32'h20c41, q)
	endtask
	task automatic t_power;
		power_good_i <= 0;
		step;
		`CHK("pwr_oe", 80'h0, pin_oe_o)
		@(posedge core_clk_i);
		power_good_i <= 1;
		test_output_enable_pin_i <= 0;
		step;
		`CHK("toe_oe", 80'h0, pin_oe_o)
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk_i);
		rst_i <= 0;
		@(posedge core_clk_i);
		t_mux;
		t_fixed;
		t_reg;
		t_pad;
		t_prot;
		t_power;
		summarize;
	end
	// watchdog: well above the few hundred bus cycles needed
	initial begin
		#400000;
		mismatches++;
		summarize;
	end
endmodule
